// ==== include/fpw_pkg.sv ====
package fpw_pkg;
    // ==========================================================
    // register map: printed offsets are word indices
    // ==========================================================
    localparam logic [15:0] IDX_CTRL = 16'h0fe0;
    localparam logic [15:0] IDX_STATUS = 16'h0fe1;
    localparam logic [15:0] IDX_EMU = 16'h0fe2;
    localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};
    localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};
    localparam logic [15:0] ADDR_EMU = {IDX_EMU[13:0], 2'b00};
    // ==========================================================
    // field positions and reset values
    // ==========================================================
    localparam int CTRL_PWR_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_STOP_BIT = 3;
    localparam int CTRL_KEY_LSB = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_WRITE_INTERRUPTED_FLAG_BIT = 2;
    localparam logic [3:0] KEY_ENABLE = 4'h3;
    localparam logic [3:0] KEY_DISABLE = 4'hc;
    localparam logic KEY_RST_PWR = 1'b1;
    localparam logic KEY_RST_AUTO = 1'b1;
    localparam logic [2:0] EMU_RST = 3'h0;
    localparam logic [2:0] EMU_CODE_MAX = 3'h4;
    localparam logic [7:0] FLASH_BLANK = 8'hff;
    // ==========================================================
    // geometry and timing
    // ==========================================================
    localparam int PAGE_BYTES = 64;
    localparam int PAGES = 8;
    localparam int TMR_W = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam int WARM_FC_LOG2 = 10;
    localparam int WARM_FS_LOG2 = 3;
    localparam logic [TMR_W-1:0] WARM_FC_CYC = TMR_W'(1 << WARM_FC_LOG2);
    localparam logic [TMR_W-1:0] WARM_FS_CYC = TMR_W'(1 << WARM_FS_LOG2);
    localparam int EMU_NORMAL_LOG2 = 16;
    localparam int EMU_SLOW_LOG2 = 7;
    localparam int PROD_WRITE_TIME_NS = 4000000;
    localparam int PROD_WRITE_CYC = PROD_WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_OFF, ST_WARM, ST_READY, ST_PROG} fpw_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic fetch;
        logic [8:0] addr;
        logic [7:0] wdata;
    } fpw_flash_req_s;
endpackage

// ==== hdl/fpw_sub_tick.sv ====
module fpw_sub_tick (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic sub_clk_i,
    output logic tick_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= sub_clk_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // one pulse per rising subclock edge
    assign tick_o = s2_r & ~s3_r;
endmodule

// ==== hdl/fpw_tick_timer.sv ====
module fpw_tick_timer #(
    parameter int W = 20
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [W-1:0] len_i,
    input wire logic tick_i,
    output logic busy_o,
    output logic done_o
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (srst_i || abort_i) begin
            cnt_r <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            cnt_r <= len_i;
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else begin
            done_o <= busy_o && tick_i && cnt_r == W'(1);
            if (busy_o && tick_i) begin
                cnt_r <= cnt_r - W'(1);
                busy_o <= cnt_r != W'(1);
            end
        end
    end
endmodule

// ==== hdl/fpw_flash_ctrl.sv ====
// Overview of operation
// [RULE_01] bytes gather in a 64-byte buffer; page programs only after all 64
// [RULE_02] status: bit2 interrupted, bit1 ready, bit0 busy; upper bits undefined
// [RULE_03] ready/busy: 1/0 empty, 1/1 writing, 0/1 off, halted or warming
// [RULE_04] nmi during write sets flag, aborts, clears counter, then warm-up wait
// [RULE_05] any status register read clears the interrupted flag
// [RULE_06] software retries a page write after finding the interrupted flag
// [RULE_07] power bit 0 to 1: ready after 2^10 fc or 2^3 fs periods
// [RULE_08] software polls ready before touching flash after power-up
// [RULE_09] while busy, flash reads return ff and fetching it raises swi
// [RULE_10] emulated time code 0..4 gives 2^16..2^12 fc or 2^7..2^3 fs
// [RULE_11] production variant keeps register but writes take fixed 4 ms
// [RULE_12] emulated time register reads bits 7 to 3 as undefined
// [RULE_13] writes allowed only with key 0011, blocked with 1100
// [RULE_14] software keeps the key at the disabling code when idle
// [RULE_15] key writes from flash execution are ignored
// [RULE_16] forcible stop writes from flash execution are ignored
// [RULE_17] stop: clear counter, halt write, warm-up wait, then busy clears
// [RULE_18] stop warm-up lasts 2^10 fc or 2^3 fs periods
// [RULE_19] after a stop the next byte lands first and sets busy
// [RULE_20] stop after 1 to 63 bytes leaves the page untouched
// [RULE_21] software avoids a stop once all 64 bytes are buffered
// [RULE_22] during warm-up the cpu waits; interrupts are held until it ends; here a power-bit warm-up raises no wait and an nmi in warm-up is dropped
// [RULE_23] nmi during warm-up does not shorten it
// [RULE_24] stop with busy low starts no warm-up wait
// [RULE_25] software leaves one machine cycle after a stop before flash access
// [RULE_26] stop bit clears itself after being written one
// [RULE_27] clearing power bit removes control power at once
// [RULE_28] counter advances per accepted byte, wraps at 64 into programming
// [RULE_29] write timer counts selected periods from start then clears busy
module fpw_flash_ctrl
    import fpw_pkg::*;
#(
    parameter bit PROD_VARIANT = 1'b0,
    parameter int PROD_WRITE_CYCLES = PROD_WRITE_CYC,
    parameter int EMU_MAX_LOG2 = EMU_NORMAL_LOG2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fpw_flash_req_s flash_req_i,
    input wire logic exec_in_flash_i,
    input wire logic nmi_i,
    input wire logic clock_select_i,
    input wire logic slow_mode_i,
    input wire logic sub_clk_i,
    output logic [7:0] flash_rdata_o,
    output logic swi_o,
    output logic cpu_wait_o,
    output logic ctrl_power_o
);
    // ==========================================================
    // state
    // ==========================================================
    fpw_state_e state_r;
    fpw_state_e state_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [2:0] page_r;
    logic [PAGE_BYTES*8-1:0] buf_r;
    logic [PAGE_BYTES*8-1:0] page_mem [PAGES];
    logic [3:0] write_protect_key;
    logic auto_r;
    logic stop_r;
    logic write_interrupted_flag;
    logic [2:0] emulated_write_time_sel;
    logic wait_nxt;

    // ==========================================================
    // apb decode
    // ==========================================================
    wire setup_rd = psel & penable & ~pready;
    wire acc = psel & penable & pready;
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_stat = paddr == ADDR_STATUS;
    wire hit_emu = paddr == ADDR_EMU;
    wire ctrl_wr = acc & pwrite & hit_ctrl;
    wire ctrl_ok = ctrl_wr & ~exec_in_flash_i;
    wire stat_rd = acc & ~pwrite & hit_stat;
    wire emu_wr = acc & pwrite & hit_emu;

    // ==========================================================
    // events
    // ==========================================================
    wire sub_tick;
    wire wu_busy;
    wire wu_done;
    wire wr_busy;
    wire wr_done;
    wire ready = state_r == ST_READY || state_r == ST_PROG;
    wire busy = !(state_r == ST_READY && cnt_r == 6'h0);
    wire writing = (state_r == ST_READY && cnt_r != 6'h0) || state_r == ST_PROG;
    wire stop_set = ctrl_ok & pwdata[CTRL_STOP_BIT];
    wire pwr_off = ctrl_ok & ~pwdata[CTRL_PWR_BIT] & ctrl_power_o;
    wire pwr_on = ctrl_ok & pwdata[CTRL_PWR_BIT] & ~ctrl_power_o;
    wire nmi_abort = nmi_i & writing;
    wire abort = (nmi_i | stop_set) & writing; // RULE_24
    wire key_open = write_protect_key == KEY_ENABLE; // RULE_13
    wire byte_ok = flash_req_i.wr & state_r == ST_READY & key_open & ~abort & ~pwr_off;
    wire blocked = busy | ~ready;
    wire [2:0] code = emulated_write_time_sel > EMU_CODE_MAX ? EMU_CODE_MAX : emulated_write_time_sel;
    wire [TMR_W-1:0] wu_len = clock_select_i ? WARM_FS_CYC : WARM_FC_CYC; // RULE_18
    wire wu_tick = clock_select_i ? sub_tick : 1'b1;
    wire [4:0] wr_shift = slow_mode_i ? 5'(EMU_SLOW_LOG2) - 5'(code) : 5'(EMU_MAX_LOG2) - 5'(code); // RULE_10
    wire [TMR_W-1:0] emu_len = TMR_W'(1) << wr_shift;
    wire [TMR_W-1:0] wr_len = PROD_VARIANT ? TMR_W'(PROD_WRITE_CYCLES) : emu_len; // RULE_11
    wire wr_tick = PROD_VARIANT ? 1'b1 : (slow_mode_i ? sub_tick : 1'b1);
    wire wu_start = state_r != ST_WARM && state_nxt == ST_WARM;
    wire wr_start = state_r != ST_PROG && state_nxt == ST_PROG;
    wire wr_abort = state_r == ST_PROG && state_nxt != ST_PROG && !wr_done;

    fpw_sub_tick u_sub_tick (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .sub_clk_i(sub_clk_i),
        .tick_o(sub_tick)
    );

    fpw_tick_timer #(.W(TMR_W)) u_warm_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(wu_start),
        .abort_i(pwr_off),
        .len_i(wu_len),
        .tick_i(wu_tick),
        .busy_o(wu_busy),
        .done_o(wu_done)
    );

    fpw_tick_timer #(.W(TMR_W)) u_write_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(wr_start),
        .abort_i(wr_abort),
        .len_i(wr_len),
        .tick_i(wr_tick),
        .busy_o(wr_busy),
        .done_o(wr_done)
    );

    // ==========================================================
    // sequencer
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wait_nxt = cpu_wait_o;
        if (pwr_off) begin
            state_nxt = ST_OFF; // RULE_27
            cnt_nxt = 6'h0;
            wait_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_OFF: begin
                    if (nmi_i || pwr_on) begin
                        state_nxt = ST_WARM; // RULE_07
                        wait_nxt = nmi_i;
                    end
                end
                ST_WARM: begin
                    // nmi here changes nothing: the wait runs to its end
                    if (wu_done) begin // RULE_23
                        state_nxt = ST_READY; // RULE_17
                        wait_nxt = 1'b0; // RULE_22
                    end
                end
                ST_READY: begin
                    if (abort) begin
                        state_nxt = ST_WARM; // RULE_04
                        cnt_nxt = 6'h0; // RULE_19
                        wait_nxt = 1'b1;
                    end else if (byte_ok) begin
                        cnt_nxt = cnt_r + 6'h1; // RULE_28
                        if (cnt_r == 6'h3f) begin
                            state_nxt = ST_PROG; // RULE_01
                        end
                    end
                end
                ST_PROG: begin
                    if (abort) begin
                        state_nxt = ST_WARM; // RULE_17
                        cnt_nxt = 6'h0;
                        wait_nxt = 1'b1;
                    end else if (wr_done) begin
                        state_nxt = ST_READY; // RULE_29
                    end
                end
                default: begin
                    state_nxt = ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= ST_READY;
            cnt_r <= 6'h0;
            cpu_wait_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cpu_wait_o <= wait_nxt;
        end
    end

    // ==========================================================
    // page buffer and data area
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (byte_ok) begin
            buf_r[cnt_r*8 +: 8] <= flash_req_i.wdata;
            page_r <= flash_req_i.addr[8:6];
        end
        // an aborted fill never reaches here, so the page keeps its data
        if (state_r == ST_PROG && wr_done && !abort) begin
            page_mem[page_r] <= buf_r; // RULE_20
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flash_rdata_o <= FLASH_BLANK;
            swi_o <= 1'b0;
        end else begin
            if (flash_req_i.rd || flash_req_i.fetch) begin
                flash_rdata_o <= blocked ? FLASH_BLANK : // RULE_09
                    page_mem[flash_req_i.addr[8:6]][flash_req_i.addr[5:0]*8 +: 8];
            end
            swi_o <= flash_req_i.fetch & blocked; // RULE_09
        end
    end

    // ==========================================================
    // control, status and emulated time registers
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            write_protect_key <= KEY_DISABLE;
            ctrl_power_o <= KEY_RST_PWR;
            auto_r <= KEY_RST_AUTO;
            stop_r <= 1'b0;
            write_interrupted_flag <= 1'b0;
            emulated_write_time_sel <= EMU_RST;
        end else begin
            if (ctrl_ok) begin
                write_protect_key <= pwdata[CTRL_KEY_LSB +: 4]; // RULE_15
            end
            if (ctrl_wr) begin
                auto_r <= pwdata[CTRL_AUTO_BIT];
            end
            if (pwr_off) begin
                ctrl_power_o <= 1'b0; // RULE_27
            end else if (pwr_on || (nmi_i && state_r == ST_OFF)) begin
                ctrl_power_o <= 1'b1;
            end
            stop_r <= stop_set & ~stop_r; // RULE_16 RULE_26
            if (nmi_abort) begin
                write_interrupted_flag <= 1'b1; // RULE_04
            end else if (stat_rd) begin
                write_interrupted_flag <= 1'b0; // RULE_05
            end
            if (emu_wr) begin
                emulated_write_time_sel <= pwdata[2:0]; // RULE_11
            end
        end
    end

    // ==========================================================
    // apb read path
    // ==========================================================
    logic [31:0] rd_nxt;
    logic err_nxt;

    always_comb begin
        rd_nxt = 32'h0;
        err_nxt = 1'b0;
        if (hit_ctrl) begin
            rd_nxt[CTRL_KEY_LSB +: 4] = write_protect_key;
            rd_nxt[CTRL_STOP_BIT] = stop_r;
            rd_nxt[CTRL_AUTO_BIT] = auto_r;
            rd_nxt[CTRL_PWR_BIT] = ctrl_power_o;
        end else if (hit_stat) begin
            rd_nxt[STAT_WRITE_INTERRUPTED_FLAG_BIT] = write_interrupted_flag; // RULE_02
            rd_nxt[STAT_READY_BIT] = ready; // RULE_03
            rd_nxt[STAT_BUSY_BIT] = busy; // RULE_03
        end else if (hit_emu) begin
            rd_nxt[2:0] = emulated_write_time_sel; // RULE_12
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_rd;
            pslverr <= setup_rd & err_nxt;
            if (setup_rd && !pwrite) begin
                prdata <= rd_nxt;
            end
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    property p_key_blocks;
        flash_req_i.wr && !key_open && state_r == ST_READY && !abort && !pwr_off |=> $stable(cnt_r);
    endproperty
    a_key_blocks: assert property (p_key_blocks) else $error("byte taken with key closed"); // RULE_13

    property p_stat_bits;
        setup_rd && !pwrite && hit_stat |=> prdata[1:0] == {$past(ready), $past(busy)};
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("status bits wrong"); // RULE_02

    property p_write_interrupted_flag_clear;
        stat_rd && !nmi_abort |=> !write_interrupted_flag;
    endproperty
    a_write_interrupted_flag_clear: assert property (p_write_interrupted_flag_clear) else $error("flag not cleared by read"); // RULE_05

    property p_nmi_abort;
        nmi_abort && !pwr_off |=> write_interrupted_flag && cpu_wait_o && cnt_r == 6'h0 && state_r == ST_WARM;
    endproperty
    a_nmi_abort: assert property (p_nmi_abort) else $error("nmi did not abort write"); // RULE_04

    property p_key_locked;
        ctrl_wr && exec_in_flash_i |=> $stable(write_protect_key) && !stop_r;
    endproperty
    a_key_locked: assert property (p_key_locked) else $error("control changed from flash"); // RULE_15

    property p_stop_self_clear;
        stop_r |=> !stop_r;
    endproperty
    a_stop_self_clear: assert property (p_stop_self_clear) else $error("stop bit stuck"); // RULE_26

    property p_power_off;
        pwr_off |=> !ready ##1 !ready;
    endproperty
    a_power_off: assert property (p_power_off) else $error("ready after power off"); // RULE_27

    property p_stop_idle;
        stop_set && !busy && !nmi_i && !pwr_off |=> !cpu_wait_o && state_r == ST_READY;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("idle stop caused wait"); // RULE_24

    property p_fill_prog;
        byte_ok && cnt_r == 6'h3f |=> state_r == ST_PROG && cnt_r == 6'h0 && busy;
    endproperty
    a_fill_prog: assert property (p_fill_prog) else $error("64th byte did not program"); // RULE_28

    property p_read_blank;
        flash_req_i.rd && busy |=> flash_rdata_o == FLASH_BLANK;
    endproperty
    a_read_blank: assert property (p_read_blank) else $error("busy read not ff"); // RULE_09

    property p_warm_fc;
        wu_start && !clock_select_i && !pwr_off |=> (state_r == ST_WARM && !ready) [*8];
    endproperty
    a_warm_fc: assert property (p_warm_fc) else $error("warm-up too short"); // RULE_18

    c_program: cover property (state_r == ST_PROG ##1 state_r == ST_READY);
    c_nmi_abort: cover property (nmi_abort);
    c_stop_abort: cover property (stop_set && writing);
    c_power_cycle: cover property (pwr_off ##[1:50] pwr_on);
endmodule

// ==== tb/fpw_cpu_model.sv ====
module fpw_cpu_model
    import fpw_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic swi_i,
    output fpw_flash_req_s req_o,
    output logic exec_o,
    output logic nmi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_o = '0;
        exec_o = 1'b0;
        nmi_o = 1'b0;
    end
    // ==========================================================
    // cpu accesses, one per cycle, held up to the taking edge
    // ==========================================================
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        req_o <= '{wr: 1'b1, rd: 1'b0, fetch: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
    endtask
    task automatic idle();
        req_o <= '{wr: 1'b0, rd: 1'b0, fetch: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [8:0] a, input logic f, output logic [7:0] d, output logic s);
        req_o <= '{wr: 1'b0, rd: !f, fetch: f, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        idle();
        d = rdata_i;
        s = swi_i;
    endtask
    task automatic nmi();
        nmi_o <= 1'b1;
        @(posedge clk_i);
        nmi_o <= 1'b0;
    endtask
    task automatic run_from(input logic f);
        exec_o <= f;
        @(posedge clk_i);
    endtask
endmodule

// ==== tb/test_fpw_flash_ctrl.sv ====
module test_fpw_flash_ctrl
    import fpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EMU_LOG2 = 8;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic cs = 1'b0;
    logic sub_clk = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fpw_flash_req_s req;
    logic exec;
    logic nmi;
    logic [7:0] frd;
    logic swi;
    logic cpu_wait;
    logic pwr;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int wcnt = 0;
    int t0;
    int mdl [512];
    logic [31:0] r;
    logic e;
    logic [7:0] d;
    logic s;

    fpw_flash_ctrl #(.EMU_MAX_LOG2(EMU_LOG2)) i_fpw_flash_ctrl (
        .clk_i(clk_i), .srst_i(srst_i), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_req_i(req), .exec_in_flash_i(exec), .nmi_i(nmi), .clock_select_i(cs),
        .slow_mode_i(slow), .sub_clk_i(sub_clk), .flash_rdata_o(frd), .swi_o(swi),
        .cpu_wait_o(cpu_wait), .ctrl_power_o(pwr));
    fpw_cpu_model i_fpw_cpu_model (
        .clk_i(clk_i), .rdata_i(frd), .swi_i(swi), .req_o(req), .exec_o(exec), .nmi_o(nmi));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        forever #51.3 sub_clk = ~sub_clk;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cpu_wait === 1'b1) wcnt++;
        if (cyc == 40000) begin
            error_cnt++;
            summarize();
        end
    end
    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk_i);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st(input logic [2:0] x);
        apb(ADDR_STATUS, 1'b0, '0);
        chk("status", r, {29'h0, x});
    endtask
    task automatic poll(input int b, input logic v);
        do begin
            apb(ADDR_STATUS, 1'b0, '0);
        end while (r[b] !== v);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
        while (cpu_wait !== 1'b0) begin
            @(posedge clk_i);
        end
    endtask
    task automatic page(input int pg, input int n, input logic keep);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            i_fpw_cpu_model.wr(9'(pg * 64 + i), d);
            if (keep) mdl[pg*64+i] = d;
        end
        i_fpw_cpu_model.idle();
    endtask
    task automatic verify(input int pg);
        for (int i = 0; i < 64; i++) begin
            i_fpw_cpu_model.rd(9'(pg * 64 + i), 1'b0, d, s);
            chk("flash byte", {24'h0, d}, 32'(mdl[pg*64+i]));
        end
    endtask
    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h58046005));
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        st(3'b010);
        apb(16'h0100, 1'b0, '0);
        chk("unmapped", {31'h0, e}, 32'h1);
        apb(ADDR_EMU, 1'b0, '0);
        chk("emu reset", r, {29'h0, EMU_RST});
        apb(ADDR_CTRL, 1'b1, 32'h33);
        for (int c = 0; c < 5; c++) begin
            apb(ADDR_EMU, 1'b1, ({$urandom} & 32'hfffffff8) | 32'(c));
            apb(ADDR_EMU, 1'b0, '0);
            chk("emu code", r, 32'(c));
            page(c, 64, 1'b1);
            t0 = cyc;
            i_fpw_cpu_model.rd(9'(c * 64), 1'b1, d, s);
            chk("busy fetch", {23'h0, s, d}, {23'h0, 1'b1, FLASH_BLANK});
            st(3'b011);
            poll(STAT_BUSY_BIT, 1'b0);
            t0 = cyc - t0 - (1 << (EMU_LOG2 - c));
            chk("write time", 32'(t0 >= 0 && t0 <= 14), 32'h1);
            verify(c);
        end
        apb(ADDR_CTRL, 1'b1, 32'hc3);
        page(1, 64, 1'b0);
        st(3'b010);
        verify(1);
        apb(ADDR_CTRL, 1'b1, 32'h33);
        page(1, 10, 1'b0);
        i_fpw_cpu_model.run_from(1'b1);
        wcnt = 0;
        apb(ADDR_CTRL, 1'b1, 32'hcb);
        apb(ADDR_CTRL, 1'b0, '0);
        i_fpw_cpu_model.run_from(1'b0);
        chk("ctrl kept", r, 32'h33);
        chk("flash stop", 32'(wcnt), 32'h0);
        st(3'b011);
        apb(ADDR_CTRL, 1'b1, 32'h3b);
        repeat (200) @(posedge clk_i);
        i_fpw_cpu_model.nmi();
        settle();
        chk("stop wait", 32'(wcnt >= 1024 && wcnt <= 1030), 32'h1);
        apb(ADDR_STATUS, 1'b0, '0);
        chk("after stop", {30'h0, r[1:0]}, 32'h2);
        apb(ADDR_CTRL, 1'b0, '0);
        chk("stop clear", r, 32'h33);
        verify(1);
        wcnt = 0;
        apb(ADDR_CTRL, 1'b1, 32'h3b);
        repeat (8) @(posedge clk_i);
        chk("idle stop", 32'(wcnt), 32'h0);
        cs <= 1'b1;
        page(3, 5, 1'b0);
        apb(ADDR_CTRL, 1'b1, 32'h3b);
        settle();
        chk("sub wait", 32'(wcnt >= 140 && wcnt <= 175), 32'h1);
        cs <= 1'b0;
        i_fpw_cpu_model.idle();
        page(3, 64, 1'b1);
        poll(STAT_BUSY_BIT, 1'b0);
        verify(3);
        page(4, 20, 1'b0);
        wcnt = 0;
        i_fpw_cpu_model.nmi();
        settle();
        chk("nmi wait", 32'(wcnt >= 1024 && wcnt <= 1030), 32'h1);
        st(3'b110);
        st(3'b010);
        page(4, 64, 1'b1);
        poll(STAT_BUSY_BIT, 1'b0);
        verify(4);
        slow <= 1'b1;
        page(5, 64, 1'b1);
        t0 = cyc;
        poll(STAT_BUSY_BIT, 1'b0);
        t0 = cyc - t0;
        chk("slow time", 32'(t0 >= 140 && t0 <= 190), 32'h1);
        slow <= 1'b0;
        verify(5);
        apb(ADDR_CTRL, 1'b1, 32'h32);
        st(3'b001);
        chk("power bit", {31'h0, pwr}, 32'h0);
        i_fpw_cpu_model.rd(9'h0, 1'b0, d, s);
        chk("off read", {24'h0, d}, {24'h0, FLASH_BLANK});
        wcnt = 0;
        apb(ADDR_CTRL, 1'b1, 32'h33);
        t0 = cyc;
        poll(STAT_READY_BIT, 1'b1);
        t0 = cyc - t0;
        chk("power up", 32'(t0 >= 1024 && t0 <= 1040 && wcnt == 0), 32'h1);
        apb(ADDR_CTRL, 1'b1, 32'hc3);
        summarize();
    end
endmodule
